/* File: hw/rlc_regbank.sv */
// Function
// R1: Writing one closes relay, zero opens.
// R2: Reset drives every relay output open.
// R3: Read-only fixed card type byte at zero.
// R4: Config byte shows two straps, high undefined.
// R5: Status bit0 ready, upper bits read one.
// R6: One settling timer longer than 4 ms.
// R7: Timer restarts on relay writes, reset.
// R8: Writing reset bit pulses board reset.
// R9: Writing open-all bit opens all relays.
// R10: Other status/control write bits are ignored.
// R11: Three mezzanine bytes, upper low nibble.
// R12: Mezzanine straps read one unless pulled.
// R13: Offset 6 drives channels 1 and 2.
// R14: Offset 7 drives channels 3 and 4.
// R15: Load registers write-only, cleared on reset.
// R16: Timer terminal count is a parameter.
`timescale 1ns/1ps
`default_nettype none
`include "rlc_regs.svh"
module rlc_regbank #(
    parameter logic [7:0]  CARD_TYPE_CODE = 8'hA5,  // Arbitrary value.
    parameter int unsigned SETTLE_US      = `RLC_SETTLE_US,
    parameter int unsigned CLK_KHZ        = `RLC_CLK_KHZ,
    parameter int unsigned SETTLE_CYCLES  = (SETTLE_US * CLK_KHZ + 999) / 1000
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // Classic Wishbone slave.
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [5:2]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Strap pins, pulled high on the card.
    input  wire logic [1:0]        cfg_straps_i,
    input  wire logic [3:0]        mezz_slot1_upper_straps_i,
    input  wire logic [3:0]        mezz_slot1_lower_straps_i,
    input  wire logic [3:0]        mezz_slot2_upper_straps_i,
    input  wire logic [3:0]        mezz_slot2_lower_straps_i,
    input  wire logic [3:0]        mezz_slot3_upper_straps_i,
    input  wire logic [3:0]        mezz_slot3_lower_straps_i,
    // Relay drives, board reset and interrupt.
    output rlc_pkg::rlc_byte_t     load_relays_ch1_ch2_o,
    output rlc_pkg::rlc_byte_t     load_relays_ch3_ch4_o,
    output logic                   board_reset_o,
    output logic                   irq_o
);
    import rlc_pkg::*;

    localparam int unsigned NSTRAP = 26;

    // SETTLE_US must exceed four milliseconds; SETTLE_CYCLES itself is only checked to be at least one.
    initial begin
        if (SETTLE_CYCLES < 1 || SETTLE_US <= 4000) begin
            $error("Settling period must exceed four milliseconds.");
        end
    end

    rlc_timer_if tif ();

    // All strap pins collected so one generate loop synchronises them.
    logic [NSTRAP-1:0] strap_raw;
    logic [NSTRAP-1:0] strap_s1_reg;   // First stage, read only by the second.
    logic [NSTRAP-1:0] strap_s2_reg;   // Second stage.
    logic [NSTRAP-1:0] strap_s3_reg;   // Third stage.
    logic [NSTRAP-1:0] strap_reg;      // Accepted value once stages agree.

    assign strap_raw = {mezz_slot3_lower_straps_i, mezz_slot3_upper_straps_i,
                        mezz_slot2_lower_straps_i, mezz_slot2_upper_straps_i,
                        mezz_slot1_lower_straps_i, mezz_slot1_upper_straps_i,
                        cfg_straps_i};

    // Straps come from pins, so each passes three stage flops and the accepted flop before use.
    genvar gi;
    generate
        for (gi = 0; gi < NSTRAP; gi++) begin : g_strap
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    strap_s1_reg[gi] <= 1'b1;
                    strap_s2_reg[gi] <= 1'b1;
                    strap_s3_reg[gi] <= 1'b1;
                    strap_reg[gi]    <= 1'b1;    // Unpulled straps read one. [R12]
                end else if (ce_i) begin
                    strap_s1_reg[gi] <= strap_raw[gi];
                    strap_s2_reg[gi] <= strap_s1_reg[gi];
                    strap_s3_reg[gi] <= strap_s2_reg[gi];
                    // Take a change only when the last two stages agree.
                    if (strap_s2_reg[gi] == strap_s3_reg[gi]) begin
                        strap_reg[gi] <= strap_s3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    // Bus decode.
    logic       req;          // A request waits that has not been acked.
    logic       wr_stb;       // Write takes effect this cycle.
    logic       lane0;        // Low byte lane enabled.
    logic [3:0] idx;          // Register word index.
    assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_stb = req && wb_we_i && ce_i;
    assign lane0  = wb_sel_i[0];
    assign idx    = wb_adr_i;

    logic wr_sc;   // Write to status and control.
    logic wr_l12;  // Write to load select 1 and 2.
    logic wr_l34;  // Write to load select 3 and 4.
    assign wr_sc  = wr_stb && lane0 && (idx == {1'b0, `RLC_IDX_STAT_CTRL});
    assign wr_l12 = wr_stb && lane0 && (idx == {1'b0, `RLC_IDX_LOAD12});
    assign wr_l34 = wr_stb && lane0 && (idx == {1'b0, `RLC_IDX_LOAD34});

    // Only the reset and open-all bits matter; the rest are dropped. [R10]
    logic do_board_reset;
    logic do_open_all;
    assign do_board_reset = wr_sc && wb_dat_i[`RLC_SC_RESET_BIT];    // [R8]
    assign do_open_all    = wr_sc && wb_dat_i[`RLC_SC_OPEN_ALL_BIT]; // [R9]

    // The ack register answers one cycle after the request appears.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    // Board reset pulse lasts one cycle; the write that raises it also opens this bank's relays on the same edge.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            board_reset_o <= 1'b0;
        end else if (ce_i) begin
            board_reset_o <= do_board_reset; // [R8]
        end
    end

    // Load select registers: one closes, zero opens. [R1] [R13] [R14]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            load_relays_ch1_ch2_o <= `RLC_LOAD_RESET; // [R2] [R15]
            load_relays_ch3_ch4_o <= `RLC_LOAD_RESET; // [R2] [R15]
        end else if (ce_i) begin
            if (do_board_reset || do_open_all) begin
                // Board reset and open-all both force every relay open. [R2] [R9]
                load_relays_ch1_ch2_o <= `RLC_LOAD_RESET;
                load_relays_ch3_ch4_o <= `RLC_LOAD_RESET;
            end else begin
                if (wr_l12) begin
                    load_relays_ch1_ch2_o <= wb_dat_i[7:0]; // [R13]
                end
                if (wr_l34) begin
                    load_relays_ch3_ch4_o <= wb_dat_i[7:0]; // [R14]
                end
            end
        end
    end

    // Any change to relay state restarts settling, including open-all and board reset. [R7]
    assign tif.restart = wr_l12 || wr_l34 || do_open_all || do_board_reset;

    rlc_settle_timer #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    ) u_timer (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .tmr   (tif.tmr)
    );

    // Ready edge detection for the interrupt event.
    logic busy_d_reg;  // Busy one cycle ago.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_d_reg <= 1'b1;
        end else if (ce_i) begin
            busy_d_reg <= tif.busy;
        end
    end

    logic [`RLC_IRQ_WIDTH-1:0] irq_event;  // Event pulses.
    assign irq_event[`RLC_IRQ_READY_BIT]    = busy_d_reg && !tif.busy;
    assign irq_event[`RLC_IRQ_OPEN_ALL_BIT] = do_open_all;

    logic wr_ist;   // Write to interrupt status.
    logic wr_imk;   // Write to interrupt mask.
    assign wr_ist = wr_stb && lane0 && (idx == `RLC_IDX_IRQ_STAT);
    assign wr_imk = wr_stb && lane0 && (idx == `RLC_IDX_IRQ_MASK);

    logic [`RLC_IRQ_WIDTH-1:0] irq_stat_reg;  // Sticky events.
    logic [`RLC_IRQ_WIDTH-1:0] irq_mask_reg;  // One enables an event.

    // Sticky status: a new event wins over a write-one clear in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat_reg <= `RLC_IRQ_ZERO;
        end else if (ce_i) begin
            irq_stat_reg <= (irq_stat_reg & ~(wr_ist ? wb_dat_i[`RLC_IRQ_WIDTH-1:0] : `RLC_IRQ_ZERO))
                            | irq_event;
        end
    end

    // Mask register, plain read and write.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_reg <= `RLC_IRQ_ZERO;
        end else if (ce_i && wr_imk) begin
            irq_mask_reg <= wb_dat_i[`RLC_IRQ_WIDTH-1:0];
        end
    end

    // Level interrupt from registers only.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_o <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // Read mux; write-only and unmapped words read zero.
    rlc_byte_t rd_byte;
    always_comb begin
        rd_byte = `RLC_BYTE_ZERO;
        unique case (idx)
            {1'b0, `RLC_IDX_CARD_ID}:   rd_byte = CARD_TYPE_CODE;                            // [R3]
            {1'b0, `RLC_IDX_CARD_CFG}:  rd_byte = {`RLC_CFG_FILL, strap_reg[1:0]};           // [R4]
            {1'b0, `RLC_IDX_STAT_CTRL}: rd_byte = `RLC_SC_FILL | {7'h00, !tif.busy};         // [R5]
            {1'b0, `RLC_IDX_MEZZ1}:     rd_byte = strap_reg[9:2];                            // [R11] [R12]
            {1'b0, `RLC_IDX_MEZZ2}:     rd_byte = strap_reg[17:10];                          // [R11] [R12]
            {1'b0, `RLC_IDX_MEZZ3}:     rd_byte = strap_reg[25:18];                          // [R11] [R12]
            `RLC_IDX_IRQ_STAT:          rd_byte = {6'h00, irq_stat_reg};
            `RLC_IDX_IRQ_MASK:          rd_byte = {6'h00, irq_mask_reg};
            default:                    rd_byte = `RLC_BYTE_ZERO;                            // [R15]
        endcase
    end

    // Read data is registered together with the ack.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (ce_i) begin
            wb_dat_o <= {24'h000000, rd_byte};
        end
    end
endmodule : rlc_regbank
`default_nettype wire

/* File: hw/rlc_regs.svh */
`ifndef RLC_REGS_SVH
`define RLC_REGS_SVH

// Register indices (byte-wide registers, one per 32-bit word).
`define RLC_IDX_CARD_ID       3'h0
`define RLC_IDX_CARD_CFG      3'h1
`define RLC_IDX_STAT_CTRL     3'h2
`define RLC_IDX_MEZZ1         3'h3
`define RLC_IDX_MEZZ2         3'h4
`define RLC_IDX_MEZZ3         3'h5
`define RLC_IDX_LOAD12        3'h6
`define RLC_IDX_LOAD34        3'h7
// Own registers for interrupt status and mask, word indices 8 and 9.
`define RLC_IDX_IRQ_STAT      4'h8
`define RLC_IDX_IRQ_MASK      4'h9

// Field positions in the status and control register.
`define RLC_SC_READY_BIT      0
`define RLC_SC_RESET_BIT      0
`define RLC_SC_OPEN_ALL_BIT   5

// Interrupt event bit positions.
`define RLC_IRQ_READY_BIT     0
`define RLC_IRQ_OPEN_ALL_BIT  1
`define RLC_IRQ_WIDTH         2

// Reset values and fill patterns.
`define RLC_LOAD_RESET        8'h00
`define RLC_SC_FILL           8'hFE
`define RLC_CFG_FILL          6'h3F
`define RLC_BYTE_ZERO         8'h00
`define RLC_IRQ_ZERO          2'h0

// Settling time in microseconds and clock rate in kHz.
`define RLC_SETTLE_US         4001
`define RLC_CLK_KHZ           40000

`endif

/* File: hw/rlc_pkg.sv */
package rlc_pkg;
    // One register byte.
    typedef logic [7:0] rlc_byte_t;
    // Settling timer states, Gray coded.
    typedef enum logic [1:0] {
        RLC_READY = 2'b00,
        RLC_BUSY  = 2'b01
    } rlc_settle_e;
endpackage : rlc_pkg

/* File: hw/rlc_timer_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Link between register bank and settling timer.
interface rlc_timer_if;
    logic restart; // One-cycle restart pulse.
    logic busy;    // High while relays settle.
    modport ctrl (output restart, input busy);
    modport tmr  (input restart, output busy);
endinterface : rlc_timer_if
`default_nettype wire

/* File: hw/rlc_settle_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rlc_regs.svh"
// Relay settling timer: counts card clocks after each restart.
module rlc_settle_timer #(
    parameter int unsigned SETTLE_CYCLES = 160040
) (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    input  wire logic  ce_i,
    rlc_timer_if.tmr   tmr
);
    import rlc_pkg::*;

    localparam int unsigned CW = $clog2(SETTLE_CYCLES + 1);

    // A counter of zero length could never report busy.
    initial begin
        if (SETTLE_CYCLES < 1) begin
            $error("SETTLE_CYCLES must be at least one.");
        end
    end

    logic [CW-1:0] count_reg;   // Cycles still to wait.
    rlc_settle_e   state_reg;   // Ready or busy.

    // Restart on reset or request; busy until the count runs out. [R6] [R7] [R16]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= CW'(SETTLE_CYCLES);
            state_reg <= RLC_BUSY;
        end else if (ce_i) begin
            if (tmr.restart) begin
                count_reg <= CW'(SETTLE_CYCLES);
                state_reg <= RLC_BUSY;
            end else begin
                unique case (state_reg)
                    RLC_BUSY: begin
                        // Leave busy only once the full period is over.
                        if (count_reg <= CW'(1)) begin
                            count_reg <= '0;
                            state_reg <= RLC_READY;
                        end else begin
                            count_reg <= count_reg - CW'(1);
                        end
                    end
                    RLC_READY: begin
                        count_reg <= '0;
                    end
                    default: begin
                        state_reg <= RLC_BUSY;
                    end
                endcase
            end
        end
    end

    // Busy follows the state directly.
    assign tmr.busy = (state_reg != RLC_READY); // [R7]
endmodule : rlc_settle_timer
`default_nettype wire

/* File: tb/rlc_regbank_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rlc_regs.svh"
// Checks the bank's port behaviour, timed from the edge at which a request is taken.
module rlc_regbank_monitor #(
    parameter logic [7:0] CARD_TYPE_CODE = 8'hA5  // Arbitrary value.
) (
    input wire logic               clk_i,
    input wire logic               rst_i,
    input wire logic               ce_i,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_we_i,
    input wire logic [5:2]         wb_adr_i,
    input wire logic [3:0]         wb_sel_i,
    input wire logic [31:0]        wb_dat_i,
    input wire logic [31:0]        wb_dat_o,
    input wire logic               wb_ack_o,
    input wire rlc_pkg::rlc_byte_t load_relays_ch1_ch2_o,
    input wire rlc_pkg::rlc_byte_t load_relays_ch3_ch4_o,
    input wire logic               board_reset_o
);
    import rlc_pkg::*;
    // A write is taken only while no ack is pending, so a held strobe is not counted twice.
    logic      wr_taken;
    logic      rd_ack;
    rlc_byte_t wr_byte;
    assign wr_taken = ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
    assign rd_ack   = wb_ack_o && !wb_we_i;
    assign wr_byte  = wb_dat_i[7:0];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_reset_open;
        $fell(rst_i) |-> load_relays_ch1_ch2_o == 8'h00 && load_relays_ch3_ch4_o == 8'h00 && !board_reset_o;
    endproperty
    a_reset_open: assert property (p_reset_open) else $error("relays not open after reset");
    property p_load12;
        wr_taken && wb_adr_i == `RLC_IDX_LOAD12 |=> load_relays_ch1_ch2_o == $past(wr_byte);
    endproperty
    a_load12: assert property (p_load12) else $error("channel 1 and 2 relays wrong");
    property p_load34;
        wr_taken && wb_adr_i == `RLC_IDX_LOAD34 |=> load_relays_ch3_ch4_o == $past(wr_byte);
    endproperty
    a_load34: assert property (p_load34) else $error("channel 3 and 4 relays wrong");
    property p_open_all;
        wr_taken && wb_adr_i == `RLC_IDX_STAT_CTRL && wb_dat_i[5]
            |=> ##[0:1] load_relays_ch1_ch2_o == 8'h00 && load_relays_ch3_ch4_o == 8'h00;
    endproperty
    a_open_all: assert property (p_open_all) else $error("open all left relays closed");
    property p_board_reset;
        wr_taken && wb_adr_i == `RLC_IDX_STAT_CTRL && wb_dat_i[0] |=> ##[0:1] board_reset_o;
    endproperty
    a_board_reset: assert property (p_board_reset) else $error("board reset not pulsed");
    property p_board_pulse;
        board_reset_o |=> !board_reset_o;
    endproperty
    a_board_pulse: assert property (p_board_pulse) else $error("board reset latched");
    property p_ignore;
        wr_taken && wb_adr_i == `RLC_IDX_STAT_CTRL && !wb_dat_i[0] && !wb_dat_i[5]
            |=> $stable(load_relays_ch1_ch2_o) && $stable(load_relays_ch3_ch4_o) && !board_reset_o;
    endproperty
    a_ignore: assert property (p_ignore) else $error("unused control bits acted");
    property p_ident;
        rd_ack && wb_adr_i == `RLC_IDX_CARD_ID |-> wb_dat_o == {24'h000000, CARD_TYPE_CODE};
    endproperty
    a_ident: assert property (p_ident) else $error("card identifier wrong");
    property p_status_fill;
        rd_ack && wb_adr_i == `RLC_IDX_STAT_CTRL |-> wb_dat_o[31:1] == {24'h000000, 7'h7F};
    endproperty
    a_status_fill: assert property (p_status_fill) else $error("status fill bits wrong");
    property p_wo_read;
        rd_ack && (wb_adr_i == `RLC_IDX_LOAD12 || wb_adr_i == `RLC_IDX_LOAD34) |-> wb_dat_o == 32'h00000000;
    endproperty
    a_wo_read: assert property (p_wo_read) else $error("write-only register read back");
endmodule : rlc_regbank_monitor
bind rlc_regbank rlc_regbank_monitor #(.CARD_TYPE_CODE(CARD_TYPE_CODE)) u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .load_relays_ch1_ch2_o(load_relays_ch1_ch2_o), .load_relays_ch3_ch4_o(load_relays_ch3_ch4_o),
    .board_reset_o(board_reset_o));
`default_nettype wire

/* File: tb/rlc_testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: a Wishbone master task, random straps and relay bytes, and corner cases.
module testbench;
    import rlc_pkg::*;
    localparam int unsigned SETTLE = 20;     // Short settling count keeps the run brief.
    localparam logic [7:0]  CARD   = 8'h3C;  // Arbitrary value.
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, brst, irq;
    logic        ce    = 1'b1;  // Clock enable, dropped once to show that state freezes.
    logic [3:0]  adr   = 4'h0;
    logic [31:0] dat_w = 32'h0, dat_o, rd, seed = 32'h713B;
    logic [1:0]  cfg   = 2'h3;
    logic [23:0] mz    = 24'hFFFFFF;
    rlc_byte_t   l12, l34, e12 = 8'h00, e34 = 8'h00, v;
    int          fail_count = 0, total_checks = 0, pulses = 0;
    rlc_regbank #(.CARD_TYPE_CODE(CARD), .SETTLE_CYCLES(SETTLE)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat_w), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .cfg_straps_i(cfg), .mezz_slot1_upper_straps_i(mz[3:0]), .mezz_slot1_lower_straps_i(mz[7:4]),
        .mezz_slot2_upper_straps_i(mz[11:8]), .mezz_slot2_lower_straps_i(mz[15:12]),
        .mezz_slot3_upper_straps_i(mz[19:16]), .mezz_slot3_lower_straps_i(mz[23:20]),
        .load_relays_ch1_ch2_o(l12), .load_relays_ch3_ch4_o(l34), .board_reset_o(brst), .irq_o(irq));
    // Free-running card clock.
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    // Board reset pulses are counted, so a latched or missing pulse shows.
    always @(posedge clk_i) begin
        if (brst === 1'b1) begin
            pulses <= pulses + 1;
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // Status byte reads all ones above the ready flag.
    function automatic logic [31:0] stat_exp(input logic r);
        return {24'h000000, 7'h7F, r};
    endfunction : stat_exp
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    // One classic cycle; the request is held until ack is sampled, then idle cycles let effects land.
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            fail_count++;
            summarize();
        end
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : bus
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check("outputs after reset", {l12, l34, brst}, 32'h0);
        for (int t = 0; t < 4; t++) begin
            seed = lfsr(seed);
            cfg <= (t == 0) ? 2'h3 : seed[1:0];
            mz <= (t == 0) ? 24'hFFFFFF : seed[31:8];
            repeat (8) @(posedge clk_i);
            bus(1'b0, 4'h0, 8'h00);
            check("card id", rd, {24'h000000, CARD});
            bus(1'b0, 4'h1, 8'h00);
            check("config", rd, {24'h000000, 6'h3F, cfg});
            for (int i = 0; i < 3; i++) begin
                bus(1'b0, 4'(3 + i), 8'h00);
                check("mezzanine", rd, {24'h000000, mz[8 * i +: 8]});
            end
        end
        $display("test straps done");
        for (int t = 0; t < 6; t++) begin
            seed = lfsr(seed);
            v = (t < 2) ? 8'hFF : (t < 4) ? 8'h00 : seed[7:0];
            bus(1'b1, 4'h6 + 4'(t % 2), v);
            if (t % 2 == 0) e12 = v; else e34 = v;
            check("loads", {l12, l34}, {e12, e34});
            bus(1'b0, 4'h6 + 4'(t % 2), 8'h00);
            check("write-only read", rd, 32'h0);
        end
        bus(1'b0, 4'h2, 8'h00);
        check("status busy", rd, stat_exp(1'b0));
        repeat (SETTLE + 8) @(posedge clk_i);
        bus(1'b0, 4'h2, 8'h00);
        check("status ready", rd, stat_exp(1'b1));
        bus(1'b1, 4'h2, 8'hDE);
        check("unused bits", {l12, l34, 8'(pulses)}, {e12, e34, 8'h00});
        $display("test loads done");
        bus(1'b1, 4'h9, 8'h00);
        bus(1'b1, 4'h8, 8'h03);
        bus(1'b1, 4'h6, 8'hFF);
        bus(1'b1, 4'h2, 8'h20);
        check("open all", {l12, l34}, 32'h0);
        repeat (SETTLE + 8) @(posedge clk_i);
        bus(1'b0, 4'h8, 8'h00);
        check("event status", rd, 32'h3);
        check("irq masked", irq, 1'b0);
        bus(1'b1, 4'h9, 8'h02);
        check("irq raised", irq, 1'b1);
        bus(1'b1, 4'h8, 8'h02);
        check("irq cleared", irq, 1'b0);
        $display("test irq done");
        bus(1'b1, 4'h7, 8'h5A);
        bus(1'b1, 4'h2, 8'h01);
        check("board reset", {l12, l34, 8'(pulses)}, 32'h1);
        // With the enable low the settling count must not advance, so busy outlasts the wait.
        ce <= 1'b0;
        repeat (SETTLE + 8) @(posedge clk_i);
        ce <= 1'b1;
        bus(1'b0, 4'h2, 8'h00);
        check("busy while frozen", rd, stat_exp(1'b0));
        $display("test enable done");
        bus(1'b0, 4'hF, 8'h00);
        check("unmapped", rd, 32'h0);
        bus(1'b1, 4'h6, 8'hC3);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, 4'h2, 8'h00);
        check("relays after reset", {l12, l34}, 32'h0);
        check("busy after reset", rd, stat_exp(1'b0));
        $display("test reset done");
        summarize();
    end
endmodule : testbench
`default_nettype wire
